// ===== addr_map_pkg.sv
package addr_map_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int FILE_W = 8;
  localparam int ELEM_W = 12;

  // ------------------------------------------------------------
  // network
  // ------------------------------------------------------------
  localparam logic [7:0] STATION_MIN = 8'h01;
  localparam logic [7:0] STATION_MAX = 8'hff;

  // ------------------------------------------------------------
  // request address ranges, one-based as seen by the master
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] COIL_LO    = 16'd1;
  localparam logic [ADDR_W-1:0] COIL_HI    = 16'd4096;
  localparam logic [ADDR_W-1:0] CONT_LO    = 16'd10001;
  localparam logic [ADDR_W-1:0] CONT_HI    = 16'd14096;
  localparam logic [ADDR_W-1:0] INREG_LO   = 16'd30001;
  localparam logic [ADDR_W-1:0] INREG_HI   = 16'd30256;
  localparam logic [ADDR_W-1:0] COMM_LO    = 16'd30501;
  localparam logic [ADDR_W-1:0] COMM_HI    = 16'd30532;
  localparam logic [ADDR_W-1:0] SYSRO_LO   = 16'd31501;
  localparam logic [ADDR_W-1:0] SYSRO_HI   = 16'd31566;
  localparam logic [ADDR_W-1:0] HOLD_LO    = 16'd40001;
  localparam logic [ADDR_W-1:0] HOLD_HI    = 16'd40256;
  localparam logic [ADDR_W-1:0] SYSRW_LO   = 16'd41501;
  localparam logic [ADDR_W-1:0] SYSRW_HI   = 16'd41566;

  // ------------------------------------------------------------
  // element base in the target file, and file numbers
  // ------------------------------------------------------------
  localparam logic [ELEM_W-1:0] SYSRO_BASE = 12'd32;
  localparam logic [FILE_W-1:0] STATUS_FILE = 8'h02;
  localparam logic [FILE_W-1:0] USER_FILE_MIN = 8'h03;

  // ------------------------------------------------------------
  // space codes, one-hot
  // ------------------------------------------------------------
  typedef enum logic [7:0] {
    SP_NONE  = 8'b0000_0001,
    SP_COIL  = 8'b0000_0010,
    SP_CONT  = 8'b0000_0100,
    SP_INREG = 8'b0000_1000,
    SP_COMM  = 8'b0001_0000,
    SP_SYSRO = 8'b0010_0000,
    SP_HOLD  = 8'b0100_0000,
    SP_SYSRW = 8'b1000_0000
  } space_t;

  // ------------------------------------------------------------
  // error codes
  // ------------------------------------------------------------
  localparam logic [1:0] ERR_NONE     = 2'h0;
  localparam logic [1:0] ERR_ADDR     = 2'h2;
  localparam logic [1:0] ERR_READONLY = 2'h3;

  // ------------------------------------------------------------
  // state machine
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_DONE = 3'b010,
    ST_WAIT = 3'b100
  } state_t;

endpackage : addr_map_pkg

// ===== map_cfg_store.sv
`timescale 1ns/1ps
// holds the four user placements; read data registered
module map_cfg_store
  import addr_map_pkg::*;
(
  // clock and reset
  input  wire logic              clk_sys_in,
  input  wire logic              rstn_in,
  input  wire logic              ce_in,
  // write port
  input  wire logic              wr_en_in,
  input  wire logic [1:0]        wr_idx_in,
  input  wire logic [FILE_W-1:0] wr_file_in,
  // read port
  input  wire logic [1:0]        rd_idx_in,
  output logic      [FILE_W-1:0] rd_file_out,
  output logic                   rd_valid_out
);

  logic [FILE_W-1:0] mem [4];
  logic [3:0]        set;

  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      for (int i = 0; i < 4; i++)
        mem[i] <= '0;
      set          <= '0;
      rd_file_out  <= '0;
      rd_valid_out <= 1'b0;
    end
    else if (ce_in)
    begin
      if (wr_en_in)
      begin
        mem[wr_idx_in] <= wr_file_in;
        set[wr_idx_in] <= 1'b1;
      end
      rd_file_out  <= mem[rd_idx_in];
      rd_valid_out <= set[rd_idx_in];
    end
  end

endmodule : map_cfg_store

// ===== master_model.sv
`timescale 1ns/1ps
module master_model
  import addr_map_pkg::*;
(
  // clock and slave answer
  input  wire logic              clk_sys_in,
  input  wire logic              req_ready_in,
  input  wire logic              rsp_valid_in,
  input  wire logic [24:0]       rsp_in,
  // request and accept
  output logic                   req_valid_out,
  output logic [7:0]             req_station_out,
  output logic                   req_write_out,
  output logic [ADDR_W-1:0]      req_addr_out,
  output logic                   rsp_ready_out
);
  initial
  begin
    {req_valid_out, req_station_out, req_write_out, rsp_ready_out} = '0;
    req_addr_out = '0;
  end
  // every exchange starts here; released lines show inverted values
  task automatic xfer(input logic [7:0] stn, input logic wr,
    input logic [ADDR_W-1:0] a, input int stall,
    output logic got, output logic [24:0] rsp);
    int n;
    got = 1'b0;
    rsp = '0;
    req_valid_out = 1'b1;
    req_station_out = stn;
    req_write_out = wr;
    req_addr_out = a;
    for (n = 0; n < 20 && req_ready_in !== 1'b1; n++) @(posedge clk_sys_in) #1;
    @(posedge clk_sys_in) #1;
    req_valid_out = 1'b0;
    req_station_out = ~stn;
    req_write_out = ~wr;
    req_addr_out = ~a;
    for (n = 0; n < 6 && rsp_valid_in !== 1'b1; n++) @(posedge clk_sys_in) #1;
    if (rsp_valid_in === 1'b1)
    begin
      got = 1'b1;
      repeat (stall) @(posedge clk_sys_in) #1;
      rsp_ready_out = 1'b1;
      @(posedge clk_sys_in);
      rsp = rsp_in;
      #1 rsp_ready_out = 1'b0;
    end
  endtask : xfer
endmodule : master_model

// ===== modbus_slave_address_map.sv
`timescale 1ns/1ps
module modbus_slave_address_map
  import addr_map_pkg::*;
(
  // clock and reset
  input  wire logic              clk_sys_in,
  input  wire logic              rstn_in,
  input  wire logic              ce_in,
  // placement configuration
  input  wire logic [7:0]        station_in,
  input  wire logic              cfg_wr_in,
  input  wire logic [1:0]        cfg_space_in,
  input  wire logic [FILE_W-1:0] cfg_file_in,
  // request from frame decoder
  input  wire logic              req_valid_in,
  input  wire logic [7:0]        req_station_in,
  input  wire logic              req_write_in,
  input  wire logic [ADDR_W-1:0] req_addr_in,
  output logic                   req_ready_out,
  // answer
  output logic                   rsp_valid_out,
  input  wire logic              rsp_ready_in,
  output logic                   rsp_ok_out,
  output logic [1:0]             rsp_err_out,
  output logic [FILE_W-1:0]      rsp_file_out,
  output logic [ELEM_W-1:0]      rsp_elem_out,
  output logic                   rsp_bit_out,
  output logic                   rsp_write_out
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic in_rng(input logic [ADDR_W-1:0] a,
                                  input logic [ADDR_W-1:0] lo,
                                  input logic [ADDR_W-1:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction : in_rng

  function automatic logic [ELEM_W-1:0] offs(input logic [ADDR_W-1:0] a,
                                             input logic [ADDR_W-1:0] lo);
    logic [ADDR_W-1:0] d;
    d = a - lo;
    return d[ELEM_W-1:0];
  endfunction : offs

  // placement slot of an address: coil, contact, input, else holding
  function automatic logic [1:0] place_idx(input logic [ADDR_W-1:0] a);
    if (in_rng(a, COIL_LO, COIL_HI))
      return 2'd0;
    else if (in_rng(a, CONT_LO, CONT_HI))
      return 2'd1;
    else if (in_rng(a, INREG_LO, INREG_HI))
      return 2'd2;
    else
      return 2'd3;
  endfunction : place_idx

  // ------------------------------------------------------------
  // request latch
  // ------------------------------------------------------------
  state_t            state;
  state_t            next_state;
  logic              wr_q;
  logic [ADDR_W-1:0] addr_q;

  // requests for other stations are never answered, not even with an error
  wire logic for_us = req_valid_in && (req_station_in == station_in)
                      && (station_in >= STATION_MIN)
                      && (station_in <= STATION_MAX);
  assign req_ready_out = (state == ST_IDLE);
  wire logic take = ce_in && req_ready_out && for_us;

  // ------------------------------------------------------------
  // range decode
  // ------------------------------------------------------------
  wire logic h_coil  = in_rng(addr_q, COIL_LO,  COIL_HI);
  wire logic h_cont  = in_rng(addr_q, CONT_LO,  CONT_HI);
  wire logic h_inreg = in_rng(addr_q, INREG_LO, INREG_HI);
  wire logic h_comm  = in_rng(addr_q, COMM_LO,  COMM_HI);
  wire logic h_sysro = in_rng(addr_q, SYSRO_LO, SYSRO_HI);
  wire logic h_hold  = in_rng(addr_q, HOLD_LO,  HOLD_HI);
  wire logic h_sysrw = in_rng(addr_q, SYSRW_LO, SYSRW_HI);

  space_t sp;
  assign sp = h_coil  ? SP_COIL  :
              h_cont  ? SP_CONT  :
              h_inreg ? SP_INREG :
              h_comm  ? SP_COMM  :
              h_sysro ? SP_SYSRO :
              h_hold  ? SP_HOLD  :
              h_sysrw ? SP_SYSRW : SP_NONE;

  wire logic user_sp = (sp == SP_COIL) || (sp == SP_CONT) ||
                       (sp == SP_INREG) || (sp == SP_HOLD);
  wire logic ro_sp   = (sp == SP_CONT) || (sp == SP_INREG) ||
                       (sp == SP_SYSRO);

  // the store read is registered, so it is addressed from the incoming
  // request; the answer edge then sees this request's placement
  wire logic [1:0] cfg_idx = place_idx(req_addr_in);

  // ------------------------------------------------------------
  // placement store
  // ------------------------------------------------------------
  // placements naming file 0-2 are ignored: those are not user data files
  wire logic cfg_ok = cfg_wr_in && (cfg_file_in >= USER_FILE_MIN);
  logic [FILE_W-1:0] user_file;
  logic              user_set;

  map_cfg_store u_store (
    .clk_sys_in   (clk_sys_in),
    .rstn_in      (rstn_in),
    .ce_in        (ce_in),
    .wr_en_in     (cfg_ok),
    .wr_idx_in    (cfg_space_in),
    .wr_file_in   (cfg_file_in),
    .rd_idx_in    (cfg_idx),
    .rd_file_out  (user_file),
    .rd_valid_out (user_set)
  );

  // ------------------------------------------------------------
  // answer composition
  // ------------------------------------------------------------
  wire logic [ELEM_W-1:0] elem =
    (sp == SP_COIL)  ? offs(addr_q, COIL_LO)  :
    (sp == SP_CONT)  ? offs(addr_q, CONT_LO)  :
    (sp == SP_INREG) ? offs(addr_q, INREG_LO) :
    (sp == SP_COMM)  ? offs(addr_q, COMM_LO)  :
    (sp == SP_SYSRO) ? offs(addr_q, SYSRO_LO) :
    (sp == SP_HOLD)  ? offs(addr_q, HOLD_LO)  :
    (sp == SP_SYSRW) ? offs(addr_q, SYSRW_LO) : '0;

  // the read-only status window runs over words 0-65 address for address,
  // but only the words from SYSRO_BASE upward may be reached through it
  wire logic sysro_low = (sp == SP_SYSRO) && (elem < SYSRO_BASE);

  wire logic [FILE_W-1:0] file =
    user_sp ? user_file : STATUS_FILE;

  wire logic unplaced = user_sp && !user_set;
  wire logic bad_addr = (sp == SP_NONE) || sysro_low || unplaced;
  wire logic ro_write = wr_q && ro_sp;
  wire logic [1:0] err =
    bad_addr ? ERR_ADDR :
    ro_write ? ERR_READONLY : ERR_NONE;

  // a refused request never grants a write, so no data file changes
  wire logic bit_sp = (sp == SP_COIL) || (sp == SP_CONT);
  wire logic wr_ok  = wr_q && (err == ERR_NONE);

  // ------------------------------------------------------------
  // control
  // ------------------------------------------------------------
  // one request at a time: a new one is taken only back in idle
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE: if (take) next_state = ST_WAIT;
      ST_WAIT: next_state = ST_DONE;
      ST_DONE: if (rsp_ready_in) next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // the answer stands until the master accepts it; ce low stretches it
  assign rsp_valid_out = (state == ST_DONE);

  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state  <= ST_IDLE;
      wr_q   <= 1'b0;
      addr_q <= '0;
    end
    else if (ce_in)
    begin
      state <= next_state;
      if (take)
      begin
        wr_q   <= req_write_in;
        addr_q <= req_addr_in;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rsp_ok_out    <= 1'b0;
      rsp_err_out   <= ERR_NONE;
      rsp_file_out  <= '0;
      rsp_elem_out  <= '0;
      rsp_bit_out   <= 1'b0;
      rsp_write_out <= 1'b0;
    end
    else if (ce_in && state == ST_WAIT)
    begin
      rsp_ok_out    <= (err == ERR_NONE);
      rsp_err_out   <= err;
      rsp_file_out  <= file;
      rsp_elem_out  <= elem;
      rsp_bit_out   <= bit_sp;
      rsp_write_out <= wr_ok;
    end
  end

endmodule : modbus_slave_address_map

// ===== modbus_slave_address_map_checker.sv
`timescale 1ns/1ps
module modbus_slave_address_map_checker
  import addr_map_pkg::*;
(
  input wire logic              clk_sys_in,
  input wire logic              rstn_in,
  input wire logic              ce_in,
  input wire logic [7:0]        station_in,
  input wire logic              req_valid_in,
  input wire logic [7:0]        req_station_in,
  input wire logic              req_write_in,
  input wire logic [ADDR_W-1:0] req_addr_in,
  input wire logic              req_ready_out,
  input wire logic              rsp_valid_out,
  input wire logic              rsp_ready_in,
  input wire logic              rsp_ok_out,
  input wire logic [1:0]        rsp_err_out,
  input wire logic [FILE_W-1:0] rsp_file_out,
  input wire logic [ELEM_W-1:0] rsp_elem_out,
  input wire logic              rsp_bit_out,
  input wire logic              rsp_write_out
);
  logic              wr_q;
  logic [ADDR_W-1:0] a_q;
  wire taken = ce_in && req_ready_out && req_valid_in
    && req_station_in == station_in && station_in != 8'h00;
  wire fixed = a_q inside {[COMM_LO:COMM_HI], [SYSRO_LO:SYSRO_HI],
    [SYSRW_LO:SYSRW_HI]};
  wire mapped = fixed || a_q inside {[COIL_LO:COIL_HI], [CONT_LO:CONT_HI],
    [INREG_LO:INREG_HI], [HOLD_LO:HOLD_HI]};
  // address of the request being answered
  always_ff @(posedge clk_sys_in or negedge rstn_in)
    if (!rstn_in) {wr_q, a_q} <= '0;
    else if (taken) {wr_q, a_q} <= {req_write_in, req_addr_in};
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  chk_take_answer: assert property (
    taken ##1 ce_in |-> !rsp_valid_out ##1 rsp_valid_out)
    else $error("answer not two cycles after take");
  chk_no_unasked: assert property (
    $rose(rsp_valid_out) |-> $past(taken, 2))
    else $error("answer without request");
  chk_other_stn: assert property (
    req_valid_in && req_ready_out && req_station_in != station_in
    |=> req_ready_out && !rsp_valid_out) else $error("foreign request taken");
  chk_rsp_hold: assert property (
    rsp_valid_out && !rsp_ready_in |=> rsp_valid_out
    && $stable({rsp_ok_out, rsp_err_out, rsp_file_out, rsp_elem_out}))
    else $error("answer dropped or changed");
  chk_coil_map: assert property (
    rsp_valid_out && rsp_ok_out && a_q inside {[COIL_LO:COIL_HI]}
    |-> rsp_bit_out && {4'h0, rsp_elem_out} == a_q - COIL_LO)
    else $error("coil bit index wrong");
  chk_hold_map: assert property (
    rsp_valid_out && rsp_ok_out && a_q inside {[HOLD_LO:HOLD_HI]}
    |-> !rsp_bit_out && {4'h0, rsp_elem_out} == a_q - HOLD_LO
    && (!wr_q || rsp_write_out)) else $error("holding word wrong");
  chk_sysro_write: assert property (
    rsp_valid_out && wr_q && a_q inside {[SYSRO_LO:SYSRO_HI]}
    |-> !rsp_ok_out && rsp_err_out == ERR_READONLY)
    else $error("read-only status written");
  chk_status_file: assert property (
    rsp_valid_out && rsp_ok_out && fixed |-> rsp_file_out == STATUS_FILE)
    else $error("fixed range not in status file");
  chk_unmapped: assert property (
    rsp_valid_out && !mapped |-> !rsp_ok_out && rsp_err_out == ERR_ADDR)
    else $error("unmapped address accepted");
  chk_sysro_map: assert property (
    rsp_valid_out && rsp_ok_out && a_q inside {[SYSRO_LO:SYSRO_HI]}
    |-> {4'h0, rsp_elem_out} == a_q - SYSRO_LO
    && rsp_elem_out >= SYSRO_BASE) else $error("status word out of range");
  chk_err_nowrite: assert property (
    rsp_valid_out && !rsp_ok_out |-> !rsp_write_out)
    else $error("write granted on error");
endmodule : modbus_slave_address_map_checker

bind modbus_slave_address_map modbus_slave_address_map_checker i_chk (
  .clk_sys_in, .rstn_in, .ce_in, .station_in, .req_valid_in,
  .req_station_in, .req_write_in, .req_addr_in, .req_ready_out,
  .rsp_valid_out, .rsp_ready_in, .rsp_ok_out, .rsp_err_out,
  .rsp_file_out, .rsp_elem_out, .rsp_bit_out, .rsp_write_out);

// ===== modbus_slave_address_map_tb.sv
`timescale 1ns/1ps
module modbus_slave_address_map_tb;
  import addr_map_pkg::*;
  logic              clk_sys_in, rstn_in, ce_in, cfg_wr_in, req_valid_in;
  logic              req_write_in, rsp_ready_in, req_ready_out;
  logic              rsp_valid_out, rsp_ok_out, rsp_bit_out, rsp_write_out;
  logic [7:0]        station_in, req_station_in, rsp_file_out, stn;
  logic [1:0]        cfg_space_in, rsp_err_out;
  logic [FILE_W-1:0] cfg_file_in;
  logic [ADDR_W-1:0] req_addr_in;
  logic [ELEM_W-1:0] rsp_elem_out;
  int                err_count, compares, cyc, stall;
  modbus_slave_address_map i_dut (.clk_sys_in, .rstn_in, .ce_in,
    .station_in, .cfg_wr_in, .cfg_space_in, .cfg_file_in, .req_valid_in,
    .req_station_in, .req_write_in, .req_addr_in, .req_ready_out,
    .rsp_valid_out, .rsp_ready_in, .rsp_ok_out, .rsp_err_out,
    .rsp_file_out, .rsp_elem_out, .rsp_bit_out, .rsp_write_out);
  master_model i_master (.clk_sys_in, .req_ready_in(req_ready_out),
    .rsp_valid_in(rsp_valid_out), .rsp_in({rsp_ok_out, rsp_err_out,
    rsp_file_out, rsp_elem_out, rsp_bit_out, rsp_write_out}),
    .req_valid_out(req_valid_in), .req_station_out(req_station_in),
    .req_write_out(req_write_in), .req_addr_out(req_addr_in),
    .rsp_ready_out(rsp_ready_in));
  initial
  begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end
  task automatic final_report;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  always @(posedge clk_sys_in)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      final_report();
    end
  end
  task automatic check(input logic [24:0] got, input logic [24:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  function automatic logic [24:0] ok(logic [7:0] f, logic [11:0] e,
    logic b, logic w);
    return {3'b100, f, e, b, w};
  endfunction : ok
  function automatic logic [24:0] bad(logic [1:0] e);
    return {1'b0, e, 22'h0};
  endfunction : bad
  // on error only the status bits and the write grant are compared
  task automatic run(input logic wr, input logic [15:0] a,
    input logic [24:0] x);
    logic        got;
    logic [24:0] r;
    i_master.xfer(stn, wr, a, stall, got, r);
    check({24'h0, got}, 25'h1);
    check(x[24] ? r : r & 25'h1c00001, x);
  endtask : run
  task automatic quiet;
    logic        got;
    logic [24:0] r;
    i_master.xfer(stn, 1'b1, COIL_LO, 0, got, r);
    check({24'h0, got}, 25'h0);
  endtask : quiet
  task automatic cfg(input logic [1:0] sp, input logic [7:0] f);
    cfg_wr_in = 1'b1;
    cfg_space_in = sp;
    cfg_file_in = f;
    @(posedge clk_sys_in) #1;
    cfg_wr_in = 1'b0;
    @(posedge clk_sys_in) #1;
  endtask : cfg
  task automatic t_place;
    run(1'b1, 16'd1, bad(ERR_ADDR));
    cfg(2'd3, 8'h02);
    run(1'b1, 16'd40001, bad(ERR_ADDR));
    cfg(2'd0, 8'h07);
    cfg(2'd1, 8'h08);
    cfg(2'd2, 8'h09);
    cfg(2'd3, 8'hff);
  endtask : t_place
  task automatic t_coil_contact;
    run(1'b1, 16'd1, ok(8'h07, 12'd0, 1'b1, 1'b1));
    run(1'b1, 16'd4096, ok(8'h07, 12'd4095, 1'b1, 1'b1));
    run(1'b1, 16'd0, bad(ERR_ADDR));
    run(1'b1, 16'd4097, bad(ERR_ADDR));
    run(1'b0, 16'd10001, ok(8'h08, 12'd0, 1'b1, 1'b0));
    run(1'b0, 16'd14096, ok(8'h08, 12'd4095, 1'b1, 1'b0));
    run(1'b1, 16'd10001, bad(ERR_READONLY));
  endtask : t_coil_contact
  task automatic t_registers;
    stall = 3;
    run(1'b0, 16'd30256, ok(8'h09, 12'd255, 1'b0, 1'b0));
    run(1'b1, 16'd30001, bad(ERR_READONLY));
    run(1'b0, 16'd30257, bad(ERR_ADDR));
    run(1'b1, 16'd40001, ok(8'hff, 12'd0, 1'b0, 1'b1));
    run(1'b1, 16'd40256, ok(8'hff, 12'd255, 1'b0, 1'b1));
    run(1'b1, 16'd40257, bad(ERR_ADDR));
    stall = 0;
  endtask : t_registers
  task automatic t_status;
    run(1'b1, 16'd30501, ok(8'h02, 12'd0, 1'b0, 1'b1));
    run(1'b1, 16'd30532, ok(8'h02, 12'd31, 1'b0, 1'b1));
    run(1'b0, 16'd31501, bad(ERR_ADDR));
    run(1'b0, 16'd31533, ok(8'h02, 12'd32, 1'b0, 1'b0));
    run(1'b0, 16'd31566, ok(8'h02, 12'd65, 1'b0, 1'b0));
    run(1'b1, 16'd31566, bad(ERR_READONLY));
    run(1'b0, 16'd31567, bad(ERR_ADDR));
    run(1'b1, 16'd41501, ok(8'h02, 12'd0, 1'b0, 1'b1));
    run(1'b1, 16'd41566, ok(8'h02, 12'd65, 1'b0, 1'b1));
  endtask : t_status
  task automatic t_station;
    stn = 8'h06;
    quiet();
    station_in = 8'hff;
    stn = 8'hff;
    run(1'b1, 16'd1, ok(8'h07, 12'd0, 1'b1, 1'b1));
    station_in = 8'h00;
    stn = 8'h00;
    quiet();
    station_in = 8'h05;
    stn = 8'h05;
    ce_in = 1'b0;
    quiet();
    ce_in = 1'b1;
  endtask : t_station
  task automatic t_reset;
    rstn_in = 1'b0;
    repeat (2) @(posedge clk_sys_in) #1;
    rstn_in = 1'b1;
    run(1'b1, 16'd1, bad(ERR_ADDR));
  endtask : t_reset
  initial
  begin
    {rstn_in, cfg_wr_in, cfg_space_in, cfg_file_in} = '0;
    ce_in = 1'b1;
    station_in = 8'h05;
    stn = 8'h05;
    repeat (16) @(posedge clk_sys_in);
    #1 rstn_in = 1'b1;
    t_place();
    t_coil_contact();
    t_registers();
    t_status();
    t_station();
    t_reset();
    final_report();
  end
endmodule : modbus_slave_address_map_tb
